// ===== rtl/uift_regs.vh
// register offsets, fields and reset values for the usb irq/frame/index/test slice
`ifndef UIFT_REGS_VH
`define UIFT_REGS_VH
`define UIFT_IDX_IRQ_EN      4'hb
`define UIFT_IDX_FRAME       4'hc
`define UIFT_IDX_EP_SEL      4'he
`define UIFT_IDX_TEST        4'hf
`define UIFT_IDX_STATUS      4'h0
`define UIFT_IDX_CTRL        4'h1
`define UIFT_IDX_EP_BUF      4'h2
`define UIFT_IRQ_EN_RST      8'h06
`define UIFT_IRQ_EN_MASK     8'h2f
`define UIFT_FRAME_MASK      16'h07ff
`define UIFT_EP_SEL_MASK     8'h0f
`define UIFT_TEST_RST        8'h00
`define UIFT_TEST_MASK       8'ha0
`define UIFT_BIT_DISCONNECT_EVENT      5
`define UIFT_BIT_SOF         3
`define UIFT_BIT_RESET       2
`define UIFT_BIT_RESUME      1
`define UIFT_BIT_SUSPEND     0
`define UIFT_BIT_FORCE_HOST  7
`define UIFT_BIT_FORCE_FS    5
`define UIFT_RESP_OKAY       2'b00
`define UIFT_RESP_SLVERR     2'b10
`endif

// ===== rtl/uift_core.v
// usb interrupt enable, frame number, endpoint index and test-mode register slice
// Function
// - enable bit 5 gates disconnect status onto the interrupt request
// - enable bit 3 gates start-of-frame status; resets to 0
// - enable bit 2 gates bus-reset status; resets to 1
// - enable bit 1 gates resume status; resets to 1
// - enable bit 0 gates suspend status; resets to 0
// - enable register 8 bits, reset 0x06, bits 7:6 and 4 read zero
// - frame register read-only, last frame in 10:0, upper bits zero
// - 4-bit endpoint index selects endpoint for indexed registers, resets 0
// - transmit and receive buffer size registers apply to indexed endpoint
// - test-mode register selects usb test modes, resets to 0x00
// - force host set before a bus_active_a rise enters host mode, ignoring data lines
// - forced host mode holds until bus_active_a clears, despite disconnect
// - force host still set re-enters host mode on next bus_active_a
// - forced host reports connection through device present flag
// - forced host takes speed from force full speed bit
// - force full speed selects full speed on usb reset, else speed follows attached_full_speed
`default_nettype none
`include "uift_regs.vh"
module uift_core #(
  parameter NUM_EP = 4
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // usb core events, one-cycle pulses
  input  wire        ev_disconnect,
  input  wire        ev_sof,
  input  wire        ev_bus_reset,
  input  wire        ev_resume,
  input  wire        ev_suspend,
  // usb core link state
  input  wire [10:0] frame_in,
  input  wire        frame_valid,
  input  wire        bus_active_a,
  input  wire        plus_data_line,
  input  wire        minus_data_line,
  input  wire        link_connected,
  input  wire        attached_full_speed,
  // outputs to usb core
  output reg  [3:0]  endpoint_selector,
  output reg  [7:0]  test_mode_out,
  output reg         host_mode,
  output reg         device_present_flag,
  output reg         full_speed,
  output reg         irq
);

  reg  [7:0]  irq_en_ff;
  reg  [10:0] frame_ff;
  reg  [3:0]  ep_sel_ff;
  reg  [7:0]  test_ff;
  reg  [7:0]  status_ff;
  reg         forced_ff;
  reg         sess_q_ff;
  reg         fs_ff;
  reg  [15:0] tx_size_ff [0:NUM_EP-1];
  reg  [15:0] rx_size_ff [0:NUM_EP-1];
  reg  [7:0]  aw_ff;
  reg         aw_has_ff;
  reg  [31:0] w_ff;
  reg  [3:0]  ws_ff;
  reg         w_has_ff;
  wire [7:0]  nxt_status;
  reg  [31:0] nxt_rdata;
  reg  [1:0]  nxt_rresp;
  reg         rd_clr;
  reg         w_ok;
  reg  [31:0] ep_rd_word;
  integer     k;
  wire [7:0]  ev_vec;
  wire        do_wr;
  wire        do_rd;
  wire [3:0]  widx;
  wire [3:0]  ridx;
  wire        ep_ok;
  wire [7:0]  gated;
  wire [31:0] ep_word [0:NUM_EP-1];

  // event bits sit at their enable positions; 7:6 and 4 have no event
  assign ev_vec[7] = 1'b0;
  assign ev_vec[6] = 1'b0;
  assign ev_vec[5] = ev_disconnect;
  assign ev_vec[4] = 1'b0;
  assign ev_vec[3] = ev_sof;
  assign ev_vec[2] = ev_bus_reset;
  assign ev_vec[1] = ev_resume;
  assign ev_vec[0] = ev_suspend;
  assign do_wr  = aw_has_ff && w_has_ff && !s_axi_bvalid;
  assign do_rd  = s_axi_arvalid && s_axi_arready;
  assign widx   = aw_ff[5:2];
  assign ridx   = s_axi_araddr[5:2];
  assign ep_ok  = ep_sel_ff < NUM_EP;

  // write decode; unmapped or high offsets get slverr; unmapped are dropped, high offsets still write the register at bits 5:2
  always @* begin
    w_ok = 1'b0;
    if (aw_ff[7:6] != 2'b00) begin
      w_ok = 1'b0;
    end else if (widx == `UIFT_IDX_IRQ_EN) begin
      w_ok = 1'b1;
    end else if (widx == `UIFT_IDX_FRAME) begin
      w_ok = 1'b1;
    end else if (widx == `UIFT_IDX_EP_SEL) begin
      w_ok = 1'b1;
    end else if (widx == `UIFT_IDX_TEST) begin
      w_ok = 1'b1;
    end else if (widx == `UIFT_IDX_STATUS) begin
      w_ok = 1'b1;
    end else if (widx == `UIFT_IDX_CTRL) begin
      w_ok = 1'b1;
    end else if (widx == `UIFT_IDX_EP_BUF) begin
      w_ok = 1'b1;
    end
  end

  // write address channel; ready pulses so each beat is seen once
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff         <= 8'h00;
      aw_has_ff     <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_has_ff && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff     <= s_axi_awaddr;
        aw_has_ff <= 1'b1;
      end else if (do_wr) begin
        aw_has_ff <= 1'b0;
      end
    end
  end

  // write data channel, taken independently of the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_ff         <= 32'h00000000;
      ws_ff        <= 4'h0;
      w_has_ff     <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_has_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff     <= s_axi_wdata;
        ws_ff    <= s_axi_wstrb;
        w_has_ff <= 1'b1;
      end else if (do_wr) begin
        w_has_ff <= 1'b0;
      end
    end
  end

  // write response follows once both halves are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UIFT_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= w_ok ? `UIFT_RESP_OKAY : `UIFT_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_ff <= `UIFT_IRQ_EN_RST;
      ep_sel_ff <= 4'h0;
      test_ff   <= `UIFT_TEST_RST;
    end else if (do_wr && ws_ff[0]) begin
      if (widx == `UIFT_IDX_IRQ_EN) begin
        irq_en_ff <= w_ff[7:0] & `UIFT_IRQ_EN_MASK;
      end else if (widx == `UIFT_IDX_EP_SEL) begin
        ep_sel_ff <= w_ff[3:0];
      end else if (widx == `UIFT_IDX_TEST) begin
        test_ff <= w_ff[7:0] & `UIFT_TEST_MASK;
      end
    end
  end

  // per-endpoint buffer setup words
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
      assign ep_word[g] = {rx_size_ff[g], tx_size_ff[g]};
      always @(posedge aclk) begin
        if (!aresetn) begin
          tx_size_ff[g] <= 16'h0000;
          rx_size_ff[g] <= 16'h0000;
        end else if (do_wr && widx == `UIFT_IDX_EP_BUF && ep_sel_ff == g) begin
          if (ws_ff[0]) tx_size_ff[g][7:0]  <= w_ff[7:0];
          if (ws_ff[1]) tx_size_ff[g][15:8] <= w_ff[15:8];
          if (ws_ff[2]) rx_size_ff[g][7:0]  <= w_ff[23:16];
          if (ws_ff[3]) rx_size_ff[g][15:8] <= w_ff[31:24];
        end
      end
    end
  endgenerate

  // pick the indexed endpoint's word; out-of-range index reads zero
  always @* begin
    ep_rd_word = 32'h00000000;
    for (k = 0; k < NUM_EP; k = k + 1) begin
      if (ep_sel_ff == k) begin
        ep_rd_word = ep_word[k];
      end
    end
  end

  // read mux; status read clears sticky bits
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = `UIFT_RESP_OKAY;
    rd_clr    = 1'b0;
    if (s_axi_araddr[7:6] != 2'b00) begin
      nxt_rresp = `UIFT_RESP_SLVERR;
    end else if (ridx == `UIFT_IDX_IRQ_EN) begin
      nxt_rdata = {24'h000000, irq_en_ff};
    end else if (ridx == `UIFT_IDX_FRAME) begin
      nxt_rdata = {21'h000000, frame_ff};
    end else if (ridx == `UIFT_IDX_EP_SEL) begin
      nxt_rdata = {28'h0000000, ep_sel_ff};
    end else if (ridx == `UIFT_IDX_TEST) begin
      nxt_rdata = {24'h000000, test_ff};
    end else if (ridx == `UIFT_IDX_STATUS) begin
      nxt_rdata = {24'h000000, status_ff};
      rd_clr    = 1'b1;
    end else if (ridx == `UIFT_IDX_CTRL) begin
      nxt_rdata = {28'h0000000, fs_ff, device_present_flag, forced_ff, host_mode};
    end else if (ridx == `UIFT_IDX_EP_BUF) begin
      if (ep_ok) begin
        nxt_rdata = ep_rd_word;
      end
    end else begin
      nxt_rresp = `UIFT_RESP_SLVERR;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `UIFT_RESP_OKAY;
    end else begin
      // pulse ready so one address is taken per read
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= nxt_rdata;
        s_axi_rresp  <= nxt_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky status per bit; a new event wins over the read clear
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_ev
      assign nxt_status[b] = ev_vec[b] | (status_ff[b] & !(do_rd && rd_clr));
      // each status bit gated by its enable
      assign gated[b]      = status_ff[b] & irq_en_ff[b];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= 8'h00;
      frame_ff  <= 11'h000;
      irq       <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      if (frame_valid) frame_ff <= frame_in;
      irq <= |gated;
    end
  end

  // register copies of index and test bits toward the usb core
  always @(posedge aclk) begin
    if (!aresetn) begin
      endpoint_selector <= 4'h0;
      test_mode_out     <= 8'h00;
    end else begin
      endpoint_selector <= ep_sel_ff;
      test_mode_out     <= test_ff;
    end
  end

  // forced state; entered only on a bus_active_a rise so a late force bit cannot grab a live bus_active_a
  always @(posedge aclk) begin
    if (!aresetn) begin
      forced_ff <= 1'b0;
      sess_q_ff <= 1'b0;
      fs_ff     <= 1'b0;
    end else begin
      sess_q_ff <= bus_active_a;
      if (bus_active_a && !sess_q_ff && test_ff[`UIFT_BIT_FORCE_HOST]) begin
        forced_ff <= 1'b1;
      end else if (!bus_active_a) begin
        forced_ff <= 1'b0;
      end
      if (ev_bus_reset) fs_ff <= test_ff[`UIFT_BIT_FORCE_FS];
    end
  end

  // role outputs; data lines deliberately not consulted while forced
  always @(posedge aclk) begin
    if (!aresetn) begin
      host_mode           <= 1'b0;
      device_present_flag <= 1'b0;
      full_speed          <= 1'b0;
    end else begin
      if (forced_ff) begin
        host_mode           <= 1'b1;
        device_present_flag <= link_connected;
      end else begin
        // normal role detection lives in the core; here only pass-through
        host_mode           <= 1'b0;
        device_present_flag <= link_connected && (plus_data_line || minus_data_line);
      end
      full_speed <= forced_ff ? test_ff[`UIFT_BIT_FORCE_FS] : (attached_full_speed | fs_ff);
    end
  end

endmodule
`default_nettype wire

// ===== dv/uift_sva.sv
// port assertions for the usb irq, frame, index and test-mode slice
`default_nettype none
module uift_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // link side
  input wire logic        ev_bus_reset,
  input wire logic        bus_active_a,
  input wire logic        link_connected,
  input wire logic [7:0]  test_mode_out,
  input wire logic [3:0]  endpoint_selector,
  input wire logic        host_mode,
  input wire logic        device_present_flag,
  input wire logic        full_speed,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset itself must be watched, so no disable here
  reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !irq && !host_mode && test_mode_out == 8'h00 && endpoint_selector == 4'h0)
    else $error("outputs not cleared by reset");
  test_bits_a: assert property ((test_mode_out & 8'h5f) == 8'h00)
    else $error("unused test bit set");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  aw_toggle_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready high two cycles");
  host_enter_a: assert property ($rose(bus_active_a) && test_mode_out[7] |-> ##[1:3] host_mode)
    else $error("forced host not entered");
  host_hold_a: assert property (host_mode && bus_active_a |=> host_mode)
    else $error("host mode left while bus_active_a up");
  host_drop_a: assert property (!bus_active_a [*3] |-> !host_mode)
    else $error("host mode kept without bus_active_a");
  dev_flag_a: assert property (host_mode && $past(host_mode) && $stable(link_connected) |-> device_present_flag == link_connected)
    else $error("device present flag wrong");
  speed_a: assert property (host_mode && ev_bus_reset |-> ##3 full_speed == $past(test_mode_out[5], 3))
    else $error("speed not taken from force bit");
  cover property ($rose(host_mode));
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind uift_core uift_sva uift_sva_i (.*);
`default_nettype wire

// ===== dv/uift_link_model.sv
// usb bus stand-in: events, frame numbers, bus_active_a and attach levels
`default_nettype none
module uift_link_model (
  // clock
  input  wire logic        aclk,
  // events, bit position as in the enable register
  output var  logic [5:0]  ev,
  output var  logic [10:0] frame_in,
  output var  logic        frame_valid,
  // bus state
  output var  logic        bus_active_a,
  output var  logic        plus_data_line,
  output var  logic        minus_data_line,
  output var  logic        link_connected,
  output var  logic        attached_full_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ev, frame_in, frame_valid, bus_active_a, link_connected, attached_full_speed} = '0;
    {plus_data_line, minus_data_line} = 2'b01;
  end
  // detached lines wander each cycle, so forced host cannot lean on them
  always @(posedge aclk) begin
    plus_data_line <= link_connected ? attached_full_speed : ~plus_data_line;
    minus_data_line <= link_connected ? ~attached_full_speed : plus_data_line;
  end
  task automatic pulse(input logic [5:0] m);
    @(posedge aclk) ev <= m;
    @(posedge aclk) ev <= 6'h00;
  endtask
  task automatic frame(input logic [10:0] f);
    @(posedge aclk) frame_in <= f;
    frame_valid <= 1'b1;
    @(posedge aclk) frame_valid <= 1'b0;
    frame_in <= ~f;
  endtask
endmodule
`default_nettype wire

// ===== dv/uift_core_tb.sv
// self-checking bench for the usb irq, frame, index and test-mode slice
`default_nettype none
module uift_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, test_mode_out;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, endpoint_selector;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [10:0] frame_in;
  logic [5:0]  ev;
  logic        frame_valid, bus_active_a, plus_data_line, minus_data_line, link_connected;
  logic        attached_full_speed, host_mode, device_present_flag, full_speed, irq;
  int          n_mismatch, checks;
  int          bits[5] = '{5, 3, 2, 1, 0};
  uift_core #(.NUM_EP(4)) uift_core_i (.*, .ev_disconnect(ev[5]), .ev_sof(ev[3]), .ev_bus_reset(ev[2]),
    .ev_resume(ev[1]), .ev_suspend(ev[0]));
  uift_link_model uift_link_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // bready and rready stay high after reset; answers are taken at the edge they are seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic complete_run;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    {s_axi_bready, s_axi_rready} <= 2'b11;
    @(posedge aclk);
    rd(8'h2c, 32'h06, 2'b00);
    rd(8'h30, 32'h0, 2'b00);
    rd(8'h38, 32'h0, 2'b00);
    rd(8'h3c, 32'h0, 2'b00);
    wr(8'h2c, 32'hff);
    rd(8'h2c, 32'h2f, 2'b00);
    foreach (bits[i]) begin
      wr(8'h2c, 32'h1 << bits[i]);
      uift_link_model_i.pulse(6'h2f & ~(6'h1 << bits[i]));
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      rd(8'h00, 32'h2f & ~(32'h1 << bits[i]), 2'b00);
      uift_link_model_i.pulse(6'h1 << bits[i]);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      rd(8'h00, 32'h1 << bits[i], 2'b00);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
    end
    uift_link_model_i.frame(11'h7ff);
    wr(8'h30, 32'hffff);
    rd(8'h30, 32'h7ff, 2'b00);
    uift_link_model_i.frame(11'h401);
    rd(8'h30, 32'h401, 2'b00);
    wr(8'h34, 32'h1, 2'b10);
    rd(8'h34, 32'h0, 2'b10);
    for (int i = 0; i < 4; i++) begin
      wr(8'h38, 32'hf0 | i);
      wr(8'h08, 32'h00110022 * (i + 1));
      rd(8'h38, i, 2'b00);
      chk({28'h0, endpoint_selector}, i);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h38, i);
      rd(8'h08, 32'h00110022 * (i + 1), 2'b00);
    end
    wr(8'h3c, 32'hff);
    rd(8'h3c, 32'ha0, 2'b00);
    uift_link_model_i.bus_active_a <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, host_mode}, 32'h1);
    uift_link_model_i.link_connected <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({31'h0, device_present_flag}, 32'h1);
    uift_link_model_i.pulse(6'h04);
    repeat (3) @(posedge aclk);
    chk({31'h0, full_speed}, 32'h1);
    uift_link_model_i.link_connected <= 1'b0;
    wr(8'h3c, 32'h80);
    uift_link_model_i.pulse(6'h04);
    repeat (3) @(posedge aclk);
    chk({29'h0, host_mode, device_present_flag, full_speed}, 32'h4);
    uift_link_model_i.bus_active_a <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({31'h0, host_mode}, 32'h0);
    uift_link_model_i.bus_active_a <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, host_mode}, 32'h1);
    complete_run;
  end
endmodule
`default_nettype wire
